// [hw/rdv_pkg.sv]
// package: offsets, field positions and masks of the date and alarm value registers
package rdv_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_DATE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_ALRM_TIME = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ALRM_DATE = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'hC;
  localparam int unsigned WREN_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0008;
  localparam logic [31:0] DATE_MASK = 32'hFFFF_FF0F;
  localparam logic [31:0] ALRM_TIME_MASK = 32'hFFFF_FF00;
  localparam logic [31:0] ALRM_DATE_MASK = 32'h00FF_FF0F;
  localparam int unsigned YEAR_TENS_LSB = 28;
  localparam int unsigned YEAR_UNITS_LSB = 24;
  localparam int unsigned MONTH_TENS_LSB = 20;
  localparam int unsigned MONTH_UNITS_LSB = 16;
  localparam int unsigned DAY_TENS_LSB = 12;
  localparam int unsigned DAY_UNITS_LSB = 8;
  localparam int unsigned WEEKDAY_LSB = 0;
  localparam int unsigned HOUR_TENS_LSB = 28;
  localparam int unsigned HOUR_UNITS_LSB = 24;
  localparam int unsigned MINUTE_TENS_LSB = 20;
  localparam int unsigned MINUTE_UNITS_LSB = 16;
  localparam int unsigned SECOND_TENS_LSB = 12;
  localparam int unsigned SECOND_UNITS_LSB = 8;
endpackage

// [hw/rdv_regs.sv]
// date, alarm time and alarm date value registers with a write-enable lock
// Operation
// - The date register holds the year tens digit in bits 31-28 and units in 27-24.
// - The date register holds month tens (0-1) in bits 23-20 and units (0-9) in 19-16.
// - The date register holds day tens (0-3) in bits 15-12 and units (0-9) in 11-8.
// - The date register holds a weekday 0-6 in bits 3-0 and bits 7-4 read zero.
// - The date register ignores writes unless control bit 3, the write enable, is one.
// - The alarm time register holds hour tens (0-2) in 31-28 and units (0-9) in 27-24.
// - The alarm time register holds minute tens (0-5) in 23-20 and units (0-9) in 19-16.
// - The alarm time register holds second tens in 15-12, units in 11-8, bits 7-0 read zero.
// - The alarm date register reads zero in 31-24 and holds month tens/units in 23-16.
// - The alarm date register holds day tens in bits 15-12 and units in bits 11-8.
// - The alarm date register holds a weekday in bits 3-0 and bits 7-4 read zero.
// - With the write enable set the value registers take writes, with it clear they are locked.
`timescale 1ns/100ps
`default_nettype none
module rdv_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [rdv_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic value_write_enable,
  output logic [3:0] year_tens_digit,
  output logic [3:0] year_units_digit,
  output logic [3:0] month_tens_digit,
  output logic [3:0] month_units_digit,
  output logic [3:0] day_tens_digit,
  output logic [3:0] day_units_digit,
  output logic [3:0] weekday_digit,
  output logic [3:0] alarm_hour_tens_digit,
  output logic [3:0] alarm_hour_units_digit,
  output logic [3:0] alarm_minute_tens_digit,
  output logic [3:0] alarm_minute_units_digit,
  output logic [3:0] alarm_second_tens_digit,
  output logic [3:0] alarm_second_units_digit,
  output logic [3:0] alarm_month_tens_digit,
  output logic [3:0] alarm_month_units_digit,
  output logic [3:0] alarm_day_tens_digit,
  output logic [3:0] alarm_day_units_digit,
  output logic [3:0] alarm_weekday_digit
);
  import rdv_pkg::*;

  logic [31:0] ctrl_ff;
  logic [31:0] date_ff;
  logic [31:0] alrm_time_ff;
  logic [31:0] alrm_date_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wr_date;
  logic wr_alrm_time;
  logic wr_alrm_date;

  ////////////////////////////////////////////////////////////////////////////////
  // write decode

  assign value_write_enable = ctrl_ff[WREN_BIT];
  // locked value registers drop the write silently; the bus never stalls
  assign wr_date = wr_en && (addr == OFS_DATE) && value_write_enable;
  assign wr_alrm_time = wr_en && (addr == OFS_ALRM_TIME) && value_write_enable;
  assign wr_alrm_date = wr_en && (addr == OFS_ALRM_DATE) && value_write_enable;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_en && (addr == OFS_CTRL)) begin
      ctrl_ff <= wdata & CTRL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // value registers: no reset, contents undefined until software writes them

  always_ff @(posedge clk) begin
    if (wr_date) begin
      date_ff <= wdata & DATE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_alrm_time) begin
      alrm_time_ff <= wdata & ALRM_TIME_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_alrm_date) begin
      alrm_date_ff <= wdata & ALRM_DATE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // field views; ranges are not enforced, software keeps digits legal

  assign year_tens_digit = date_ff[YEAR_TENS_LSB +: 4];
  assign year_units_digit = date_ff[YEAR_UNITS_LSB +: 4];
  assign month_tens_digit = date_ff[MONTH_TENS_LSB +: 4];
  assign month_units_digit = date_ff[MONTH_UNITS_LSB +: 4];
  assign day_tens_digit = date_ff[DAY_TENS_LSB +: 4];
  assign day_units_digit = date_ff[DAY_UNITS_LSB +: 4];
  assign weekday_digit = date_ff[WEEKDAY_LSB +: 4];
  assign alarm_hour_tens_digit = alrm_time_ff[HOUR_TENS_LSB +: 4];
  assign alarm_hour_units_digit = alrm_time_ff[HOUR_UNITS_LSB +: 4];
  assign alarm_minute_tens_digit = alrm_time_ff[MINUTE_TENS_LSB +: 4];
  assign alarm_minute_units_digit = alrm_time_ff[MINUTE_UNITS_LSB +: 4];
  assign alarm_second_tens_digit = alrm_time_ff[SECOND_TENS_LSB +: 4];
  assign alarm_second_units_digit = alrm_time_ff[SECOND_UNITS_LSB +: 4];
  assign alarm_month_tens_digit = alrm_date_ff[MONTH_TENS_LSB +: 4];
  assign alarm_month_units_digit = alrm_date_ff[MONTH_UNITS_LSB +: 4];
  assign alarm_day_tens_digit = alrm_date_ff[DAY_TENS_LSB +: 4];
  assign alarm_day_units_digit = alrm_date_ff[DAY_UNITS_LSB +: 4];
  assign alarm_weekday_digit = alrm_date_ff[WEEKDAY_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////////
  // read path; masking again on read keeps zero bits zero even before first write

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (addr)
        OFS_DATE: nxt_rdata = date_ff & DATE_MASK;
        OFS_ALRM_TIME: nxt_rdata = alrm_time_ff & ALRM_TIME_MASK;
        OFS_ALRM_DATE: nxt_rdata = alrm_date_ff & ALRM_DATE_MASK;
        OFS_CTRL: nxt_rdata = ctrl_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_date_locked;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_DATE && !value_write_enable) |=> $stable(date_ff);
  endproperty
  a_date_locked: assert property (p_date_locked) else $error("date changed while locked");

  property p_date_write;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_DATE && value_write_enable)
        |=> date_ff == ($past(wdata) & DATE_MASK);
  endproperty
  a_date_write: assert property (p_date_write) else $error("date write lost");

  property p_atime_locked;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_ALRM_TIME && !value_write_enable) |=> $stable(alrm_time_ff);
  endproperty
  a_atime_locked: assert property (p_atime_locked) else $error("alarm time changed while locked");

  property p_adate_locked;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_ALRM_DATE && !value_write_enable) |=> $stable(alrm_date_ff);
  endproperty
  a_adate_locked: assert property (p_adate_locked) else $error("alarm date changed while locked");

  property p_date_zero_bits;
    @(posedge clk) disable iff (!rst_b)
      (rd_en && addr == OFS_DATE) |=> rdata[7:4] == 4'h0;
  endproperty
  a_date_zero_bits: assert property (p_date_zero_bits) else $error("date bits 7-4 not zero");

  property p_atime_zero_bits;
    @(posedge clk) disable iff (!rst_b)
      (rd_en && addr == OFS_ALRM_TIME) |=> rdata[7:0] == 8'h00;
  endproperty
  a_atime_zero_bits: assert property (p_atime_zero_bits) else $error("alarm time low byte set");

  property p_adate_zero_bits;
    @(posedge clk) disable iff (!rst_b)
      (rd_en && addr == OFS_ALRM_DATE) |=> (rdata[31:24] == 8'h00 && rdata[7:4] == 4'h0);
  endproperty
  a_adate_zero_bits: assert property (p_adate_zero_bits) else $error("alarm date zero bits set");

  property p_atime_readback;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_ALRM_TIME && value_write_enable) ##1 (rd_en && addr == OFS_ALRM_TIME)
        |=> rdata == ($past(wdata, 2) & ALRM_TIME_MASK);
  endproperty
  a_atime_readback: assert property (p_atime_readback) else $error("alarm time readback wrong");

  property p_idle_read_zero;
    @(posedge clk) disable iff (!rst_b)
      !rd_en |=> rdata == 32'h0000_0000;
  endproperty
  a_idle_read_zero: assert property (p_idle_read_zero) else $error("read data outside read slot");

  ////////////////////////////////////////////////////////////////////////////////
  // field checks use literal bit slices so a wrong position constant cannot hide

  property p_ctrl_write;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_CTRL) |=> ctrl_ff == ($past(wdata) & CTRL_MASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_atime_write;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_ALRM_TIME && value_write_enable)
        |=> alrm_time_ff == ($past(wdata) & ALRM_TIME_MASK);
  endproperty
  a_atime_write: assert property (p_atime_write) else $error("alarm time write lost");

  property p_adate_write;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_ALRM_DATE && value_write_enable)
        |=> alrm_date_ff == ($past(wdata) & ALRM_DATE_MASK);
  endproperty
  a_adate_write: assert property (p_adate_write) else $error("alarm date write lost");

  property p_date_fields;
    @(posedge clk) disable iff (!rst_b)
      wr_date |=> {year_tens_digit, year_units_digit, month_tens_digit, month_units_digit,
        day_tens_digit, day_units_digit} == $past(wdata[31:8])
        && weekday_digit == $past(wdata[3:0]);
  endproperty
  a_date_fields: assert property (p_date_fields) else $error("date fields");

  property p_atime_fields;
    @(posedge clk) disable iff (!rst_b)
      wr_alrm_time |=> {alarm_hour_tens_digit, alarm_hour_units_digit, alarm_minute_tens_digit,
        alarm_minute_units_digit, alarm_second_tens_digit, alarm_second_units_digit}
        == $past(wdata[31:8]);
  endproperty
  a_atime_fields: assert property (p_atime_fields) else $error("alarm time");

  property p_adate_fields;
    @(posedge clk) disable iff (!rst_b)
      wr_alrm_date |=> {alarm_month_tens_digit, alarm_month_units_digit, alarm_day_tens_digit,
        alarm_day_units_digit} == $past(wdata[23:8])
        && alarm_weekday_digit == $past(wdata[3:0]);
  endproperty
  a_adate_fields: assert property (p_adate_fields) else $error("alarm date");

  property p_date_zero_store;
    @(posedge clk) disable iff (!rst_b)
      wr_date |=> date_ff[7:4] == 4'h0;
  endproperty
  a_date_zero_store: assert property (p_date_zero_store) else $error("date spare");

  property p_atime_zero_store;
    @(posedge clk) disable iff (!rst_b)
      wr_alrm_time |=> alrm_time_ff[7:0] == 8'h00;
  endproperty
  a_atime_zero_store: assert property (p_atime_zero_store) else $error("time spare");

  property p_adate_zero_store;
    @(posedge clk) disable iff (!rst_b)
      wr_alrm_date |=> alrm_date_ff[31:24] == 8'h00 && alrm_date_ff[7:4] == 4'h0;
  endproperty
  a_adate_zero_store: assert property (p_adate_zero_store) else $error("alarm spare");

  property p_ctrl_spare_zero;
    @(posedge clk) disable iff (!rst_b)
      (rd_en && addr == OFS_CTRL) |=> (rdata & ~CTRL_MASK) == 32'h0000_0000;
  endproperty
  a_ctrl_spare_zero: assert property (p_ctrl_spare_zero) else $error("control spare");

  // stale read data must not leak through an unmapped offset
  property p_unmapped_read;
    @(posedge clk) disable iff (!rst_b)
      (rd_en && addr != OFS_DATE && addr != OFS_ALRM_TIME && addr != OFS_ALRM_DATE
        && addr != OFS_CTRL) |=> rdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // a read right after a write must already see the new contents
  property p_date_readback;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_DATE && value_write_enable) ##1 (rd_en && addr == OFS_DATE)
        |=> rdata == ($past(wdata, 2) & DATE_MASK);
  endproperty
  a_date_readback: assert property (p_date_readback) else $error("date readback wrong");

  property p_adate_readback;
    @(posedge clk) disable iff (!rst_b)
      (wr_en && addr == OFS_ALRM_DATE && value_write_enable) ##1 (rd_en && addr == OFS_ALRM_DATE)
        |=> rdata == ($past(wdata, 2) & ALRM_DATE_MASK);
  endproperty
  a_adate_readback: assert property (p_adate_readback) else $error("alarm date readback");

  c_locked_write: cover property (@(posedge clk) wr_en && addr == OFS_DATE && !value_write_enable);
  c_open_write: cover property (@(posedge clk) wr_en && addr == OFS_ALRM_DATE && value_write_enable);
  c_read_date: cover property (@(posedge clk) rd_en && addr == OFS_DATE);
  c_no_gap_read: cover property (@(posedge clk) wr_en && value_write_enable ##1 rd_en);
  c_unmapped_read: cover property (@(posedge clk) rd_en && addr == 4'h2);
endmodule
`default_nettype wire

// [verif/test_rdv_regs.sv]
// self-checking bench for the date and alarm value registers
`timescale 1ns/100ps
`default_nettype none
module test_rdv_regs;
  import rdv_pkg::*;
  logic clk, rst_b, wr_en, rd_en, value_write_enable;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] yt, yu, mt, mu, dt, du, wd, ht, hu, nt, nu, st, su, amt, amu, adt, adu, awd;
  int miscompares, check_count, cycles;
  rdv_regs dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .value_write_enable(value_write_enable),
    .year_tens_digit(yt), .year_units_digit(yu), .month_tens_digit(mt),
    .month_units_digit(mu), .day_tens_digit(dt), .day_units_digit(du), .weekday_digit(wd),
    .alarm_hour_tens_digit(ht), .alarm_hour_units_digit(hu), .alarm_minute_tens_digit(nt),
    .alarm_minute_units_digit(nu), .alarm_second_tens_digit(st),
    .alarm_second_units_digit(su), .alarm_month_tens_digit(amt),
    .alarm_month_units_digit(amu), .alarm_day_tens_digit(adt),
    .alarm_day_units_digit(adu), .alarm_weekday_digit(awd));
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // the whole sequence needs well under a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      miscompares++;
      $display("MISMATCH at %0t: run did not finish", $time);
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one idle cycle between strobes keeps each strobe assigned once per time step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask
  // write then read with no idle cycle between, as the bus allows
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [31:0] d,
    input logic [31:0] exp, input string what);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    chk({31'h0, value_write_enable}, 32'h0000_0000, "enable in reset");
    rst_b <= 1'b1;
    rd(OFS_CTRL, 32'h0000_0000, "control after reset");
    wr(OFS_DATE, 32'h1234_5678);
    wr(OFS_CTRL, 32'hFFFF_FFFF);
    rd(OFS_CTRL, CTRL_MASK, "control unlocked");
    chk({31'h0, value_write_enable}, 32'h0000_0001, "enable set");
    $display("test unlock done");
    wr(OFS_DATE, 32'hFFFF_FFFF);
    rd(OFS_DATE, 32'hFFFF_FF0F, "date zero bits");
    wr(OFS_DATE, 32'h2512_3106);
    rd(OFS_DATE, 32'h2512_3106, "date value");
    chk({4'h0, yt, yu, mt, mu, dt, du, wd}, 32'h0251_2316, "date digits");
    wr(OFS_ALRM_TIME, 32'h2359_59FF);
    rd(OFS_ALRM_TIME, 32'h2359_5900, "alarm time");
    chk({8'h00, ht, hu, nt, nu, st, su}, 32'h0023_5959, "alarm time digits");
    wr(OFS_ALRM_DATE, 32'hFF12_31F6);
    rd(OFS_ALRM_DATE, 32'h0012_3106, "alarm date");
    chk({12'h000, amt, amu, adt, adu, awd}, 32'h0001_2316, "alarm date digits");
    $display("test field layout done");
    wr(OFS_CTRL, 32'h0000_0000);
    chk({31'h0, value_write_enable}, 32'h0000_0000, "enable cleared");
    wr(OFS_DATE, 32'h9999_9999);
    wr(OFS_ALRM_TIME, 32'h1111_1111);
    wr(OFS_ALRM_DATE, 32'h0101_0101);
    rd(OFS_DATE, 32'h2512_3106, "locked date");
    rd(OFS_ALRM_TIME, 32'h2359_5900, "locked alarm time");
    rd(OFS_ALRM_DATE, 32'h0012_3106, "locked alarm date");
    chk({4'h0, yt, yu, mt, mu, dt, du, wd}, 32'h0251_2316, "locked date digits");
    $display("test lock done");
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0000_0000, "unmapped read");
    rd(OFS_DATE, 32'h2512_3106, "date after unmapped write");
    $display("test unmapped done");
    wr(OFS_CTRL, CTRL_MASK);
    wr_rd(OFS_DATE, 32'h9907_04F5, 32'h9907_0405, "date no gap");
    wr_rd(OFS_ALRM_TIME, 32'h0815_42AA, 32'h0815_4200, "alarm time no gap");
    wr_rd(OFS_ALRM_DATE, 32'hAA09_30F3, 32'h0009_3003, "alarm date no gap");
    $display("test no gap done");
    wrap_up();
  end
endmodule
`default_nettype wire
